/* File: ccdc_chk_assertions.sv */
// Port-level assertions for the clock control block.
`include "ccdc_consts.vh"
module ccdc_chk (
	// Clock, reset and register bus.
	input wire clk_i,
	input wire sys_rst_i,
	input wire [15:0] mem_addr_i,
	input wire mem_wr_i,
	input wire mem_rd_i,
	input wire [7:0] mem_wdata_i,
	input wire [7:0] mem_rdata_o,
	// Oscillator status and option inputs.
	input wire hs_int_osc_ready_i,
	input wire ls_stop_allowed_i,
	input wire main_clock_select_i,
	// Oscillator controls, pin usage and clock strobes.
	input wire hs_int_osc_en_o,
	input wire ls_osc_en_o,
	input wire crystal_oscillator_en_o,
	input wire ext_clock_en_o,
	input wire pin1_port_o,
	input wire pin2_port_o,
	input wire cpu_clk_tick_o,
	input wire instr_slot_o,
	input wire periph_clk_tick_o,
	input wire main_clock_status_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// One clock domain, so reset silences every check in one place.
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_periph_undivided: assert property (!$past(sys_rst_i) |-> periph_clk_tick_o)
		else $error("peripheral tick missing");
	a_slot_on_tick: assert property (instr_slot_o |-> cpu_clk_tick_o)
		else $error("instruction slot without cpu tick");
	a_xtal_pins_free: assert property (crystal_oscillator_en_o |->
		!pin1_port_o && !pin2_port_o && !ext_clock_en_o)
		else $error("crystal mode with port pins");
	a_ext_clock_pins: assert property (ext_clock_en_o |-> pin1_port_o && !pin2_port_o)
		else $error("external clock pin decode wrong");
	a_hs_stop_write: assert property (mem_wr_i && mem_addr_i == `CCDC_ADDR_INT_OSC |->
		##2 hs_int_osc_en_o == !$past(mem_wdata_i[`CCDC_BIT_HS_INT_STOP], 2))
		else $error("internal oscillator enable wrong");
	a_ls_stop_gated: assert property (!ls_stop_allowed_i [*3] |-> ls_osc_en_o)
		else $error("low-speed oscillator stopped without option");
	a_status_lag_two: assert property (!$past(sys_rst_i, 2) && !$past(sys_rst_i)
		|-> main_clock_status_o == $past(main_clock_select_i, 2))
		else $error("main clock status does not follow select");
	a_reserved_read_zero: assert property (mem_rd_i &&
		(mem_addr_i == `CCDC_ADDR_PIN_MODE || mem_addr_i == `CCDC_ADDR_HS_OSC)
		|=> mem_rdata_o[5:0] == 6'h00)
		else $error("reserved bits read nonzero");
	a_stable_needs_ready: assert property (!hs_int_osc_ready_i [*6] ##1
		(mem_rd_i && mem_addr_i == `CCDC_ADDR_INT_OSC) |=> !mem_rdata_o[7])
		else $error("stable flag without ready");
	c_slot: cover property (instr_slot_o);
	c_xtal: cover property (crystal_oscillator_en_o);
	c_ext: cover property (ext_clock_en_o);
	c_ls_stop: cover property (!ls_osc_en_o);
endmodule // ccdc_chk
bind ccdc_top ccdc_chk u_chk (.*);

/* File: ccdc_consts.vh */
// Register map, field positions, reset values and divider codes for the clock control block.
`ifndef CCDC_CONSTS_VH
`define CCDC_CONSTS_VH
`define CCDC_ADDR_PIN_MODE 16'hFF9F
`define CCDC_ADDR_INT_OSC 16'hFFA0
`define CCDC_ADDR_HS_OSC 16'hFFA2
`define CCDC_ADDR_CPU_DIV 16'hFFFB
`define CCDC_RST_PIN_MODE 8'h00
`define CCDC_RST_INT_OSC 8'h00
`define CCDC_RST_HS_OSC 8'h80
`define CCDC_RST_CPU_DIV 8'h01
`define CCDC_BIT_EXT_CLK_SEL 7
`define CCDC_BIT_OSC_SEL 6
`define CCDC_BIT_HS_INT_STABLE 7
`define CCDC_BIT_LS_OSC_STOP 1
`define CCDC_BIT_HS_INT_STOP 0
`define CCDC_BIT_HS_SYS_STOP 7
`define CCDC_DIV_MSB 2
`define CCDC_DIV_BY1 3'h0
`define CCDC_DIV_BY2 3'h1
`define CCDC_DIV_BY4 3'h2
`define CCDC_DIV_BY8 3'h3
`define CCDC_DIV_BY16 3'h4
`define CCDC_CPU_CLKS_PER_INSTR 2'h2
`endif

/* File: ccdc_top.v */
// Clock source selection, oscillator control and CPU clock divider with its register file.
// Function
// - Pin mode register resets to zero, port pins.
// - Pin mode pair decodes port, crystal, external.
// - Divider register resets to divide by two.
// - Divider codes give one, two, four, eight, sixteen.
// - Peripheral clock stays undivided main clock.
// - Fastest instruction takes two CPU clocks.
// - Oscillator mode reads zero, then stable flag.
// - Read-only bit seven shows high-speed stability.
// - Bit one stops the low-speed oscillator.
// - Low-speed stop needs option permission.
// - Bit zero stops the high-speed internal oscillator.
// - High-speed control resets with stop set.
// - Stop bit gates crystal or external clock.
// - Main clock status shows selected clock source.
// - CPU starts on internal oscillator after reset.
`include "ccdc_consts.vh"

module ccdc_top (
	// Clock and reset.
	input wire clk_i,
	input wire sys_rst_i,
	// Internal memory bus, same clock domain.
	input wire [15:0] mem_addr_i,
	input wire mem_wr_i,
	input wire mem_rd_i,
	input wire [7:0] mem_wdata_i,
	output reg [7:0] mem_rdata_o,
	// Oscillator status and option inputs.
	input wire hs_int_osc_ready_i,
	input wire ls_stop_allowed_i,
	input wire main_clock_select_i,
	// Oscillator and pin controls.
	output reg hs_int_osc_en_o,
	output reg ls_osc_en_o,
	output reg crystal_oscillator_en_o,
	output reg ext_clock_en_o,
	output reg pin1_port_o,
	output reg pin2_port_o,
	// Clock strobes and status.
	output reg cpu_clk_tick_o,
	output reg instr_slot_o,
	output reg periph_clk_tick_o,
	output reg main_clock_status_o
);

	// Registered state.
	reg external_clock_select_ff;
	reg oscillator_select_ff;
	reg [`CCDC_DIV_MSB:0] div_code_ff;
	reg [`CCDC_DIV_MSB:0] div_act_ff;
	reg [3:0] div_cnt_ff;
	reg instr_phase_ff;
	reg low_speed_osc_stop_ff;
	reg hs_internal_osc_stop_ff;
	reg hs_internal_osc_stable_ff;
	reg hs_system_clock_stop_ff;
	reg [2:0] ready_sync_ff;
	reg ready_filt_ff;
	reg main_clock_status_ff;

	// Next values.
	reg [3:0] nxt_div_cnt;
	reg [`CCDC_DIV_MSB:0] nxt_div_act;
	reg nxt_tick;
	reg [7:0] nxt_rdata;

	wire wr_pin_mode;
	wire wr_int_osc;
	wire wr_hs_osc;
	wire wr_cpu_div;

	// Reset images of the registers; only the fields with storage are sliced out of them.
	localparam [7:0] rst_pin_mode = `CCDC_RST_PIN_MODE;
	localparam [7:0] rst_int_osc = `CCDC_RST_INT_OSC;
	localparam [7:0] rst_hs_osc = `CCDC_RST_HS_OSC;
	localparam [7:0] rst_cpu_div = `CCDC_RST_CPU_DIV;

	// Last count of a divider period; prohibited codes fall back to sixteen.
	function [3:0] div_last;
		input [`CCDC_DIV_MSB:0] code;
		begin
			case (code)
				`CCDC_DIV_BY1: div_last = 4'h0;
				`CCDC_DIV_BY2: div_last = 4'h1;
				`CCDC_DIV_BY4: div_last = 4'h3;
				`CCDC_DIV_BY8: div_last = 4'h7;
				`CCDC_DIV_BY16: div_last = 4'hF;
				default: div_last = 4'hF;
			endcase
		end
	endfunction

	// Address decode of the four registers.
	assign wr_pin_mode = mem_wr_i && (mem_addr_i == `CCDC_ADDR_PIN_MODE);
	assign wr_int_osc = mem_wr_i && (mem_addr_i == `CCDC_ADDR_INT_OSC);
	assign wr_hs_osc = mem_wr_i && (mem_addr_i == `CCDC_ADDR_HS_OSC);
	assign wr_cpu_div = mem_wr_i && (mem_addr_i == `CCDC_ADDR_CPU_DIV);

	// Software-writable fields; reserved bits have no storage at all.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			external_clock_select_ff <= rst_pin_mode[`CCDC_BIT_EXT_CLK_SEL];
			oscillator_select_ff <= rst_pin_mode[`CCDC_BIT_OSC_SEL];
			div_code_ff <= rst_cpu_div[`CCDC_DIV_MSB:0];
			low_speed_osc_stop_ff <= rst_int_osc[`CCDC_BIT_LS_OSC_STOP];
			hs_internal_osc_stop_ff <= rst_int_osc[`CCDC_BIT_HS_INT_STOP];
			hs_system_clock_stop_ff <= rst_hs_osc[`CCDC_BIT_HS_SYS_STOP];
		end else begin
			if (wr_pin_mode) begin
				external_clock_select_ff <= mem_wdata_i[`CCDC_BIT_EXT_CLK_SEL];
				oscillator_select_ff <= mem_wdata_i[`CCDC_BIT_OSC_SEL];
			end
			if (wr_cpu_div) begin
				div_code_ff <= mem_wdata_i[`CCDC_DIV_MSB:0];
			end
			if (wr_int_osc) begin
				low_speed_osc_stop_ff <= mem_wdata_i[`CCDC_BIT_LS_OSC_STOP];
				hs_internal_osc_stop_ff <= mem_wdata_i[`CCDC_BIT_HS_INT_STOP];
			end
			if (wr_hs_osc) begin
				hs_system_clock_stop_ff <= mem_wdata_i[`CCDC_BIT_HS_SYS_STOP];
			end
		end
	end

	// The ready level comes from the analog oscillator, so it passes three flops and
	// only changes the filtered copy once the second and third stages agree.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ready_sync_ff <= 3'h0;
			ready_filt_ff <= 1'b0;
		end else begin
			ready_sync_ff <= {ready_sync_ff[1:0], hs_int_osc_ready_i};
			if (ready_sync_ff[1] == ready_sync_ff[2]) begin
				ready_filt_ff <= ready_sync_ff[2];
			end
		end
	end

	// Stable flag reads zero after release and rises by itself; it drops one
	// cycle after the stop bit is set, since it is registered from that bit.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hs_internal_osc_stable_ff <= rst_int_osc[`CCDC_BIT_HS_INT_STABLE];
		end else begin
			hs_internal_osc_stable_ff <= ready_filt_ff && !hs_internal_osc_stop_ff;
		end
	end

	// Main clock status follows the select line; reset leaves the internal source.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			main_clock_status_ff <= 1'b0;
		end else begin
			main_clock_status_ff <= main_clock_select_i;
		end
	end

	// The active ratio only changes at a period boundary, so no short CPU period
	// is ever produced when software rewrites the divider mid-period.
	always @* begin
		nxt_div_cnt = div_cnt_ff + 4'h1;
		nxt_div_act = div_act_ff;
		nxt_tick = 1'b0;
		if (div_cnt_ff >= div_last(div_act_ff)) begin
			nxt_div_cnt = 4'h0;
			nxt_div_act = div_code_ff;
			nxt_tick = 1'b1;
		end
	end

	// Divider counter and CPU clock strobes.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_cnt_ff <= 4'h0;
			div_act_ff <= rst_cpu_div[`CCDC_DIV_MSB:0];
			instr_phase_ff <= 1'b0;
			cpu_clk_tick_o <= 1'b0;
			instr_slot_o <= 1'b0;
			periph_clk_tick_o <= 1'b0;
		end else begin
			div_cnt_ff <= nxt_div_cnt;
			div_act_ff <= nxt_div_act;
			cpu_clk_tick_o <= nxt_tick;
			periph_clk_tick_o <= 1'b1;
			if (nxt_tick) begin
				instr_phase_ff <= ~instr_phase_ff;
			end
			instr_slot_o <= nxt_tick && instr_phase_ff;
		end
	end

	// Oscillator enables and pin usage decoded from the control fields.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hs_int_osc_en_o <= 1'b1;
			ls_osc_en_o <= 1'b1;
			crystal_oscillator_en_o <= 1'b0;
			ext_clock_en_o <= 1'b0;
			pin1_port_o <= 1'b1;
			pin2_port_o <= 1'b1;
			main_clock_status_o <= 1'b0;
		end else begin
			hs_int_osc_en_o <= !hs_internal_osc_stop_ff;
			ls_osc_en_o <= !(low_speed_osc_stop_ff && ls_stop_allowed_i);
			crystal_oscillator_en_o <= !external_clock_select_ff && oscillator_select_ff
				&& !hs_system_clock_stop_ff;
			ext_clock_en_o <= external_clock_select_ff && oscillator_select_ff
				&& !hs_system_clock_stop_ff;
			pin1_port_o <= !(oscillator_select_ff && !external_clock_select_ff);
			pin2_port_o <= !oscillator_select_ff;
			main_clock_status_o <= main_clock_status_ff;
		end
	end

	// Read mux; unmapped addresses and reserved bits read as zero.
	always @* begin
		nxt_rdata = 8'h00;
		case (mem_addr_i)
			`CCDC_ADDR_PIN_MODE: begin
				nxt_rdata[`CCDC_BIT_EXT_CLK_SEL] = external_clock_select_ff;
				nxt_rdata[`CCDC_BIT_OSC_SEL] = oscillator_select_ff;
			end
			`CCDC_ADDR_INT_OSC: begin
				nxt_rdata[`CCDC_BIT_HS_INT_STABLE] = hs_internal_osc_stable_ff;
				nxt_rdata[`CCDC_BIT_LS_OSC_STOP] = low_speed_osc_stop_ff;
				nxt_rdata[`CCDC_BIT_HS_INT_STOP] = hs_internal_osc_stop_ff;
			end
			`CCDC_ADDR_HS_OSC: begin
				nxt_rdata[`CCDC_BIT_HS_SYS_STOP] = hs_system_clock_stop_ff;
			end
			`CCDC_ADDR_CPU_DIV: begin
				nxt_rdata[`CCDC_DIV_MSB:0] = div_code_ff;
			end
			default: begin
				nxt_rdata = 8'h00;
			end
		endcase
	end

	// Read data is registered and held until the next read.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mem_rdata_o <= 8'h00;
		end else if (mem_rd_i) begin
			mem_rdata_o <= nxt_rdata;
		end
	end

endmodule // ccdc_top

/* File: ccdc_top_tb.sv */
// Self-checking bench for the clock control block.
`include "ccdc_consts.vh"
module ccdc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, sys_rst_i = 1, mem_wr_i = 0, mem_rd_i = 0;
	logic hs_int_osc_ready_i = 0, ls_stop_allowed_i = 0, main_clock_select_i = 0;
	logic [15:0] mem_addr_i = 16'h0000;
	logic [7:0] mem_wdata_i = 8'h00, rd_v;
	wire [7:0] mem_rdata_o;
	wire hs_int_osc_en_o, ls_osc_en_o, crystal_oscillator_en_o, ext_clock_en_o, pin1_port_o;
	wire pin2_port_o, cpu_clk_tick_o, instr_slot_o, periph_clk_tick_o, main_clock_status_o;
	int fail_count = 0, compares = 0, cyc = 0, nt, ns, np;
	// Rows of address, value written, value read back; reserved bits must drop out.
	logic [31:0] rows [8] = '{32'hFF9FFFC0, 32'hFF9F4040, 32'hFFFBFF07, 32'hFFFB0404,
		32'hFFA2FF80, 32'hFFA20000, 32'hFFA0FF03, 32'h1234FF00};
	ccdc_top dut (.*);
	// Free-running clock, 5 ns period.
	always #2.5 clk_i = ~clk_i;
	// A hang is cut short well past the expected run length.
	always @(posedge clk_i) if (++cyc == 5000) begin
		fail_count++;
		end_of_test();
	end
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_cnt(input int got, input int exp);
		compares++;
		if (got != exp) begin
			fail_count++;
			$display("[ERR] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic rst();
		sys_rst_i = 1;
		repeat (16) @(negedge clk_i);
		sys_rst_i = 0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_i);
		mem_addr_i = a;
		mem_wdata_i = d;
		mem_wr_i = 1;
		@(negedge clk_i);
		mem_wr_i = 0;
	endtask
	// Read data is registered at the read edge, so it is settled by the next falling edge.
	task automatic rd(input logic [15:0] a);
		@(negedge clk_i);
		mem_addr_i = a;
		mem_rd_i = 1;
		@(negedge clk_i);
		mem_rd_i = 0;
		rd_v = mem_rdata_o;
	endtask
	task automatic count64();
		nt = 0;
		ns = 0;
		np = 0;
		repeat (64) begin
			@(negedge clk_i);
			nt += (cpu_clk_tick_o === 1'b1);
			ns += (instr_slot_o === 1'b1);
			np += (periph_clk_tick_o === 1'b1);
		end
	endtask
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Main sequence: register rows, a mid-run reset, then the awkward cases.
	initial begin
		rst();
		foreach (rows[i]) begin
			wr(rows[i][31:16], rows[i][15:8]);
			rd(rows[i][31:16]);
			chk_val(rd_v, rows[i][7:0]);
		end
		rst();
		rd(`CCDC_ADDR_PIN_MODE);
		chk_val(rd_v, 8'h00);
		rd(`CCDC_ADDR_INT_OSC);
		chk_val(rd_v, 8'h00);
		rd(`CCDC_ADDR_HS_OSC);
		chk_val(rd_v, 8'h80);
		rd(`CCDC_ADDR_CPU_DIV);
		chk_val(rd_v, 8'h01);
		chk_val(8'({hs_int_osc_en_o, pin1_port_o, pin2_port_o, main_clock_status_o}), 8'h0E);
		// A prohibited code is counted as divide by sixteen.
		for (int c = 0; c < 6; c++) begin
			wr(`CCDC_ADDR_CPU_DIV, 8'(c));
			repeat (32) @(negedge clk_i);
			count64();
			chk_cnt(nt, 64 >> (c > 4 ? 4 : c));
			chk_cnt(ns, 32 >> (c > 4 ? 4 : c));
			chk_cnt(np, 64);
		end
		hs_int_osc_ready_i = 1;
		repeat (10) @(negedge clk_i);
		rd(`CCDC_ADDR_INT_OSC);
		chk_val(rd_v, 8'h80);
		// The CPU is moved off the internal oscillator before that oscillator is stopped.
		main_clock_select_i = 1;
		repeat (3) @(negedge clk_i);
		chk_val(8'(main_clock_status_o), 8'h01);
		wr(`CCDC_ADDR_INT_OSC, 8'h01);
		repeat (2) @(negedge clk_i);
		chk_val(8'(hs_int_osc_en_o), 8'h00);
		rd(`CCDC_ADDR_INT_OSC);
		chk_val(rd_v, 8'h01);
		wr(`CCDC_ADDR_INT_OSC, 8'h02);
		main_clock_select_i = 0;
		repeat (3) @(negedge clk_i);
		chk_val(8'({ls_osc_en_o, hs_int_osc_en_o}), 8'h03);
		ls_stop_allowed_i = 1;
		repeat (3) @(negedge clk_i);
		chk_val(8'(ls_osc_en_o), 8'h00);
		chk_val(8'(main_clock_status_o), 8'h00);
		// The stop bit is cleared only in modes that use the pins.
		for (int m = 0; m < 4; m++) begin
			wr(`CCDC_ADDR_HS_OSC, 8'h80);
			rd(`CCDC_ADDR_HS_OSC);
			chk_val(rd_v, 8'h80);
			wr(`CCDC_ADDR_PIN_MODE, 8'(m << 6));
			if (m[0]) wr(`CCDC_ADDR_HS_OSC, 8'h00);
			repeat (2) @(negedge clk_i);
			chk_val(8'({pin1_port_o, pin2_port_o, crystal_oscillator_en_o, ext_clock_en_o}),
				8'({m != 1, !m[0], m == 1, m == 3}));
		end
		main_clock_select_i = 1;
		repeat (3) @(negedge clk_i);
		chk_val(8'(main_clock_status_o), 8'h01);
		end_of_test();
	end
endmodule // ccdc_top_tb
